// [verilog/drtsc_ctrl.sv]
// Ramp time selection, jog, emergency stop, base block and preset loader
// Functional notes
// - two select inputs pick ramp set one..four
// - switch-over frequency picks set one or four
// - assigned select inputs beat automatic switch-over
// - jog times span zero to full, 0.1..600s
// - jog frequency is reference while jogging
// - emergency input ramps down, raises halt indication
// - restart only after run and halt removed
// - base block turns output off at once
// - analog characteristic positive or inverse, both inputs
// - preset codes accepted; zero does 60Hz init
// - pump preset values
// - HVAC preset values
// - compressor preset values
// - modified list caps at 250 entries
// - normal ramp times 0.1..6000s, zero to full
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module drtsc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Terminal functions and drive state
    input wire logic sel_time_one,
    input wire logic sel_time_two,
    input wire logic run_cmd,
    input wire logic jog_cmd,
    input wire logic emergency_in,
    input wire logic base_block_in,
    input wire logic modified_event,
    input wire logic [16:0] output_freq,
    input wire logic [16:0] main_freq_ref,
    input wire logic [11:0] analog_voltage_input_one,
    input wire logic [11:0] analog_input_two,
    // Results
    output logic [1:0] ramp_set,
    output logic [15:0] accel_time,
    output logic [15:0] decel_time,
    output logic [16:0] freq_ref,
    output logic output_enable,
    output logic run_active,
    output logic emergency_halt_indication,
    output logic [11:0] analog_ref_one,
    output logic [11:0] analog_ref_two,
    output logic irq
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [4:0] ctrl;
    logic [15:0] acc_time [4], dec_time [4];
    logic [16:0] sw_freq, jog_freq;
    logic [15:0] jog_acc, jog_dec, estop_time;
    logic [2:0] app_sel;
    logic [3:0] irq_stat, irq_mask;
    logic [7:0] mod_count;
    // Preset image: control mode, direction lock, restart, stall, function
    logic vf_mode, fwd_lock, restart_en, stall_decel, carrier_auto, half_mid_volt;
    logic [7:0] carrier;
    logic [1:0] app_func;
    logic [6:0] base_hz;
    drtsc_pkg::drtsc_state_type state, next_state;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    wire wr_ctrl = reg_write && reg_addr == drtsc_pkg::ADDR_CTRL;
    wire wr_sw = reg_write && reg_addr == drtsc_pkg::ADDR_SWFREQ;
    wire wr_jogf = reg_write && reg_addr == drtsc_pkg::ADDR_JOGFREQ;
    wire wr_joga = reg_write && reg_addr == drtsc_pkg::ADDR_JOGACC;
    wire wr_jogd = reg_write && reg_addr == drtsc_pkg::ADDR_JOGDEC;
    wire wr_est = reg_write && reg_addr == drtsc_pkg::ADDR_ESTOP;
    wire wr_app = reg_write && reg_addr == drtsc_pkg::ADDR_APP;
    wire wr_istat = reg_write && reg_addr == drtsc_pkg::ADDR_IRQ_STAT;
    wire wr_imask = reg_write && reg_addr == drtsc_pkg::ADDR_IRQ_MASK;
    wire wr_modcnt = reg_write && reg_addr == drtsc_pkg::ADDR_MODCNT;
    wire [15:0] wtime = reg_wdata[15:0];
    // Out-of-range times are clamped rather than refused, so software never sees a stuck value
    wire [15:0] time_clamped = (wtime < drtsc_pkg::TIME_MIN) ? drtsc_pkg::TIME_MIN :
        (wtime > drtsc_pkg::TIME_MAX) ? drtsc_pkg::TIME_MAX : wtime;
    wire [15:0] jog_clamped = (wtime < drtsc_pkg::TIME_MIN) ? drtsc_pkg::TIME_MIN :
        (wtime > drtsc_pkg::JOG_TIME_MAX) ? drtsc_pkg::JOG_TIME_MAX : wtime;
    wire [16:0] freq_lim = ctrl[drtsc_pkg::CTRL_HIFREQ] ? drtsc_pkg::FREQ_MAX_HI : drtsc_pkg::FREQ_MAX_LO;
    wire [16:0] wfreq = (reg_wdata[16:0] > freq_lim) ? freq_lim : reg_wdata[16:0];
    wire app_legal = reg_wdata[2:0] != 3'h2 && reg_wdata[2:0] < 3'h6;
    wire app_take = wr_app && app_legal;

    // ****************************************************************
    // Ramp set selection, recomputed every cycle
    // ****************************************************************
    wire sel_assigned = ctrl[drtsc_pkg::CTRL_SEL_ONE_EN] || ctrl[drtsc_pkg::CTRL_SEL_TWO_EN];
    wire sel_a = ctrl[drtsc_pkg::CTRL_SEL_ONE_EN] && sel_time_one;
    wire sel_b = ctrl[drtsc_pkg::CTRL_SEL_TWO_EN] && sel_time_two;
    wire [1:0] terminal_set = {sel_b, sel_a};
    wire [1:0] auto_set = (output_freq >= sw_freq) ? 2'h3 : 2'h0;
    wire auto_on = sw_freq != 17'h00000;
    wire [1:0] next_set = sel_assigned ? terminal_set : (auto_on ? auto_set : 2'h0);
    wire jogging = jog_cmd && state == drtsc_pkg::DRTSC_RUN;
    // The ramp generator reads these live, so a set change alters a ramp in flight
    assign ramp_set = next_set;
    assign accel_time = jogging ? jog_acc : acc_time[next_set];
    assign decel_time = (state == drtsc_pkg::DRTSC_EHALT) ? estop_time :
        (jogging ? jog_dec : dec_time[next_set]);
    assign freq_ref = jogging ? jog_freq : main_freq_ref;
    assign output_enable = !base_block_in && state != drtsc_pkg::DRTSC_IDLE
        && state != drtsc_pkg::DRTSC_LOCK;
    assign run_active = state == drtsc_pkg::DRTSC_RUN;
    assign emergency_halt_indication = state == drtsc_pkg::DRTSC_EHALT || state == drtsc_pkg::DRTSC_LOCK;

    // ****************************************************************
    // Analog characteristic
    // ****************************************************************
    wire inverse = ctrl[drtsc_pkg::CTRL_INVERSE];
    assign analog_ref_one = inverse ? drtsc_pkg::ANALOG_FULL - analog_voltage_input_one
        : analog_voltage_input_one;
    assign analog_ref_two = inverse ? drtsc_pkg::ANALOG_FULL - analog_input_two : analog_input_two;

    // ****************************************************************
    // Stop state machine
    // ****************************************************************
    // Halt ends with the frequency at zero or under base block; the lock stays until run, jog and emergency all drop
    always_comb begin
        next_state = state;
        unique case (state)
            drtsc_pkg::DRTSC_IDLE: begin
                if (emergency_in) begin
                    next_state = drtsc_pkg::DRTSC_LOCK;
                end else if (run_cmd || jog_cmd) begin
                    next_state = drtsc_pkg::DRTSC_RUN;
                end
            end
            drtsc_pkg::DRTSC_RUN: begin
                if (emergency_in) begin
                    next_state = drtsc_pkg::DRTSC_EHALT;
                end else if (!run_cmd && !jog_cmd) begin
                    next_state = drtsc_pkg::DRTSC_IDLE;
                end
            end
            drtsc_pkg::DRTSC_EHALT: begin
                if (output_freq == 17'h00000 || base_block_in) next_state = drtsc_pkg::DRTSC_LOCK;
            end
            drtsc_pkg::DRTSC_LOCK: begin
                if (!run_cmd && !jog_cmd && !emergency_in) next_state = drtsc_pkg::DRTSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) state <= drtsc_pkg::DRTSC_IDLE;
        else state <= next_state;
    end

    // ****************************************************************
    // Ramp time registers, one per set
    // ****************************************************************
    for (genvar i = 0; i < 4; i++) begin : g_set
        wire wr_acc = reg_write && reg_addr == drtsc_pkg::ADDR_ACC0 + 8'(4 * i);
        wire wr_dec = reg_write && reg_addr == drtsc_pkg::ADDR_DEC0 + 8'(4 * i);
        wire comp_load = app_take && reg_wdata[2:0] == drtsc_pkg::APP_COMP && i == 0;
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                acc_time[i] <= drtsc_pkg::RST_RAMP_TIME;
                dec_time[i] <= drtsc_pkg::RST_RAMP_TIME;
            end else if (comp_load) begin
                acc_time[i] <= drtsc_pkg::PRESET_ACC_TIME;
                dec_time[i] <= drtsc_pkg::PRESET_ACC_TIME;
            end else begin
                if (wr_acc) acc_time[i] <= time_clamped;
                if (wr_dec) dec_time[i] <= time_clamped;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 5'h00;
            sw_freq <= 17'h00000;
            jog_freq <= drtsc_pkg::RST_JOG_FREQ;
            jog_acc <= drtsc_pkg::RST_RAMP_TIME;
            jog_dec <= drtsc_pkg::RST_RAMP_TIME;
            estop_time <= drtsc_pkg::RST_RAMP_TIME;
        end else begin
            if (wr_ctrl) ctrl <= reg_wdata[4:0];
            if (wr_sw) sw_freq <= wfreq;
            if (wr_jogf) jog_freq <= wfreq;
            if (wr_joga) jog_acc <= jog_clamped;
            if (wr_jogd) jog_dec <= jog_clamped;
            if (wr_est) estop_time <= (wtime > drtsc_pkg::ESTOP_TIME_MAX) ? drtsc_pkg::ESTOP_TIME_MAX : wtime;
        end
    end

    // ****************************************************************
    // Application preset loader
    // ****************************************************************
    // Reserved codes are refused and leave the whole preset image untouched
    wire [2:0] code = reg_wdata[2:0];
    wire load_common = app_take && code != drtsc_pkg::APP_DEFAULT;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            app_sel <= 3'h0;
            vf_mode <= 1'b0;
            fwd_lock <= 1'b0;
            restart_en <= 1'b0;
            stall_decel <= 1'b0;
            carrier_auto <= 1'b0;
            carrier <= 8'h00;
            app_func <= 2'h0;
            half_mid_volt <= 1'b0;
            base_hz <= drtsc_pkg::INIT_BASE_HZ;
        end else if (app_take) begin
            app_sel <= code;
            if (code == drtsc_pkg::APP_DEFAULT) begin
                vf_mode <= 1'b0;
                fwd_lock <= 1'b0;
                restart_en <= 1'b0;
                stall_decel <= 1'b0;
                carrier_auto <= 1'b0;
                carrier <= 8'h00;
                app_func <= 2'h0;
                half_mid_volt <= 1'b0;
                base_hz <= drtsc_pkg::INIT_BASE_HZ;
            end
            if (load_common) begin
                vf_mode <= 1'b1;
                fwd_lock <= 1'b1;
                restart_en <= 1'b1;
            end
            if (code == drtsc_pkg::APP_PUMP || code == drtsc_pkg::APP_FAN || code == drtsc_pkg::APP_COMP) begin
                stall_decel <= 1'b1;
            end
            if (code == drtsc_pkg::APP_PUMP) app_func <= drtsc_pkg::FUNC_PUMP;
            if (code == drtsc_pkg::APP_HVAC) begin
                carrier <= drtsc_pkg::PRESET_CARRIER;
                carrier_auto <= 1'b1;
                app_func <= drtsc_pkg::FUNC_HVAC;
            end
            if (code == drtsc_pkg::APP_COMP) begin
                app_func <= drtsc_pkg::FUNC_COMP;
                half_mid_volt <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Modified-parameter list count and interrupts
    // ****************************************************************
    // Entries past the cap are dropped, so the list keeps the first ones
    wire mod_take = modified_event && ctrl[drtsc_pkg::CTRL_MODLIST] && mod_count < drtsc_pkg::MOD_LIST_MAX;
    wire [3:0] irq_event = {wr_app && !app_legal, app_take,
        base_block_in && state == drtsc_pkg::DRTSC_RUN,
        state == drtsc_pkg::DRTSC_RUN && next_state == drtsc_pkg::DRTSC_EHALT};
    wire [3:0] irq_clear = wr_istat ? reg_wdata[3:0] : 4'h0;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_count <= 8'h00;
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            if (wr_modcnt) mod_count <= 8'h00;
            else if (mod_take) mod_count <= mod_count + 8'h01;
            irq_stat <= (irq_stat & ~irq_clear) | irq_event; // Set wins over clear
            if (wr_imask) irq_mask <= reg_wdata[3:0];
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // ****************************************************************
    // Read path, data one cycle after the strobe
    // ****************************************************************
    wire [31:0] status_word = {8'h00, app_func, half_mid_volt, carrier_auto, stall_decel,
        restart_en, fwd_lock, vf_mode, base_hz[5:0], carrier, state};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (reg_addr)
            drtsc_pkg::ADDR_CTRL: rd_mux = {27'h0, ctrl};
            8'h04, 8'h08, 8'h0c, 8'h10: rd_mux = {16'h0, acc_time[reg_addr[3:2] - 2'h1]};
            8'h14, 8'h18, 8'h1c, 8'h20: rd_mux = {16'h0, dec_time[reg_addr[3:2] - 2'h1]};
            drtsc_pkg::ADDR_SWFREQ: rd_mux = {15'h0, sw_freq};
            drtsc_pkg::ADDR_JOGFREQ: rd_mux = {15'h0, jog_freq};
            drtsc_pkg::ADDR_JOGACC: rd_mux = {16'h0, jog_acc};
            drtsc_pkg::ADDR_JOGDEC: rd_mux = {16'h0, jog_dec};
            drtsc_pkg::ADDR_ESTOP: rd_mux = {16'h0, estop_time};
            drtsc_pkg::ADDR_APP: rd_mux = {29'h0, app_sel};
            drtsc_pkg::ADDR_STATUS: rd_mux = {28'h0, ramp_set, emergency_halt_indication, output_enable};
            drtsc_pkg::ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            drtsc_pkg::ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            drtsc_pkg::ADDR_PRESET: rd_mux = status_word;
            drtsc_pkg::ADDR_MODCNT: rd_mux = {24'h0, mod_count};
            default: rd_mux = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) reg_rdata <= 32'h00000000;
        else reg_rdata <= reg_read ? rd_mux : 32'h00000000;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_terminal_set_pick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl[4:3] == 2'h3) |-> ramp_set == {sel_time_two, sel_time_one}) else $error("terminal ramp set wrong");
    a_auto_set_pick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl[4:3] == 2'h0 && sw_freq != 17'h0) |-> ramp_set == ((output_freq >= sw_freq) ? 2'h3 : 2'h0))
        else $error("automatic ramp set wrong");
    a_terminal_over_auto: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl[4:3] == 2'h3 && !sel_time_one && !sel_time_two) |-> ramp_set == 2'h0) else $error("auto beat select");
    a_jog_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (jog_cmd && run_active) |-> (freq_ref == jog_freq && accel_time == jog_acc)) else $error("jog ref unused");
    a_estop_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (run_active && emergency_in) |=> (emergency_halt_indication && decel_time == estop_time))
        else $error("emergency halt not entered");
    a_no_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == drtsc_pkg::DRTSC_LOCK && (run_cmd || jog_cmd || emergency_in)) |=> state == drtsc_pkg::DRTSC_LOCK)
        else $error("restart during emergency lock");
    a_block_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        base_block_in |-> !output_enable) else $error("output on under base block");
    a_inverse_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
        inverse |-> (analog_ref_one + analog_voltage_input_one == 12'hfff)) else $error("inverse analog map wrong");
    a_list_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mod_count <= drtsc_pkg::MOD_LIST_MAX) else $error("modified list over cap");
    a_comp_preset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_app && reg_wdata[2:0] == 3'h5) |=> (acc_time[0] == 16'h0032 && app_func == 2'h3))
        else $error("compressor preset not loaded");
endmodule : drtsc_ctrl
`default_nettype wire

// [verilog/drtsc_pkg.sv]
// Package: constants, register map and types of the ramp and stop controller
package drtsc_pkg;
    // ****************************************************************
    // Register offsets (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACC0 = 8'h04; // Accel time set one, four words
    localparam logic [7:0] ADDR_DEC0 = 8'h14; // Decel time set one, four words
    localparam logic [7:0] ADDR_SWFREQ = 8'h24;
    localparam logic [7:0] ADDR_JOGFREQ = 8'h28;
    localparam logic [7:0] ADDR_JOGACC = 8'h2c;
    localparam logic [7:0] ADDR_JOGDEC = 8'h30;
    localparam logic [7:0] ADDR_ESTOP = 8'h34;
    localparam logic [7:0] ADDR_APP = 8'h38;
    localparam logic [7:0] ADDR_STATUS = 8'h3c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
    localparam logic [7:0] ADDR_PRESET = 8'h48;
    localparam logic [7:0] ADDR_MODCNT = 8'h4c;
    // ****************************************************************
    // Control register field positions
    // ****************************************************************
    localparam int CTRL_INVERSE = 0;
    localparam int CTRL_HIFREQ = 1;
    localparam int CTRL_MODLIST = 2;
    localparam int CTRL_SEL_ONE_EN = 3;
    localparam int CTRL_SEL_TWO_EN = 4;
    // ****************************************************************
    // Reset values and limits (times in 0.1 s, frequency in 0.01 Hz)
    // ****************************************************************
    localparam logic [15:0] RST_RAMP_TIME = 16'h0064;
    localparam logic [15:0] TIME_MIN = 16'h0001;
    localparam logic [15:0] TIME_MAX = 16'hea60;
    localparam logic [15:0] JOG_TIME_MAX = 16'h1770;
    localparam logic [15:0] ESTOP_TIME_MAX = 16'hea60;
    localparam logic [16:0] RST_JOG_FREQ = 17'h00258;
    localparam logic [16:0] FREQ_MAX_LO = 17'h09c40;
    localparam logic [16:0] FREQ_MAX_HI = 17'h1d4c0;
    localparam logic [15:0] PRESET_ACC_TIME = 16'h0032;
    localparam logic [7:0] PRESET_CARRIER = 8'h50;
    localparam logic [7:0] MOD_LIST_MAX = 8'hfa;
    localparam logic [11:0] ANALOG_FULL = 12'hfff;
    // ****************************************************************
    // Application codes and function selection values
    // ****************************************************************
    localparam logic [2:0] APP_DEFAULT = 3'h0;
    localparam logic [2:0] APP_PUMP = 3'h1;
    localparam logic [2:0] APP_FAN = 3'h3;
    localparam logic [2:0] APP_HVAC = 3'h4;
    localparam logic [2:0] APP_COMP = 3'h5;
    localparam logic [1:0] FUNC_PUMP = 2'h1;
    localparam logic [1:0] FUNC_HVAC = 2'h2;
    localparam logic [1:0] FUNC_COMP = 2'h3;
    localparam logic [6:0] INIT_BASE_HZ = 7'h3c;
    localparam int IRQ_ESTOP = 0;
    localparam int IRQ_BLOCK = 1;
    localparam int IRQ_PRESET = 2;
    localparam int IRQ_BAD_APP = 3;
    // Stop state of the drive
    typedef enum logic [1:0] {DRTSC_IDLE, DRTSC_RUN, DRTSC_EHALT, DRTSC_LOCK} drtsc_state_type;
endpackage : drtsc_pkg

// [tb/drtsc_switches.sv]
// Partner model: terminal switches wired to the drive's digital inputs
`timescale 1ns/100ps
`default_nettype none
module drtsc_switches (
    // Clock and wanted switch positions
    input wire logic clk_sys,
    input wire logic [5:0] want,
    // Switch levels {base, emergency, jog, run, sel two, sel one}
    output logic [5:0] level
);
    // Contacts move just after an edge; the operator drops run and halt to rearm
    always_ff @(posedge clk_sys) begin
        level <= want;
    end
endmodule : drtsc_switches
`default_nettype wire

// [tb/drtsc_ctrl_tb_top.sv]
// Testbench: scenarios for ramp selection, stops, analog sense and presets
`timescale 1ns/100ps
`default_nettype none
module drtsc_ctrl_tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, modified_event = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
    logic [5:0] want = 6'h00, level;
    logic [16:0] output_freq = 17'h0, freq_ref, main_ref = 17'h0abc;
    logic [11:0] ain_one = 12'h100, ain_two = 12'h0ff, ref_one, ref_two;
    logic [1:0] ramp_set;
    logic [15:0] accel_time, decel_time;
    logic output_enable, run_active, halt_ind, irq;
    int n_errors = 0, checked = 0;
    // ****************************************************************
    // Clock, partner and design
    // ****************************************************************
    initial forever #25 clk_sys = ~clk_sys;
    drtsc_switches u_drtsc_switches (.clk_sys(clk_sys), .want(want), .level(level));
    drtsc_ctrl u_drtsc_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sel_time_one(level[0]),
        .sel_time_two(level[1]), .run_cmd(level[2]), .jog_cmd(level[3]), .emergency_in(level[4]),
        .base_block_in(level[5]), .modified_event(modified_event), .output_freq(output_freq),
        .main_freq_ref(main_ref), .analog_voltage_input_one(ain_one), .analog_input_two(ain_two),
        .ramp_set(ramp_set), .accel_time(accel_time), .decel_time(decel_time), .freq_ref(freq_ref),
        .output_enable(output_enable), .run_active(run_active), .emergency_halt_indication(halt_ind),
        .analog_ref_one(ref_one), .analog_ref_two(ref_two), .irq(irq));
    // ****************************************************************
    // Bus cycles and comparison
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 got = reg_rdata; // Data stand only in this cycle
    endtask : rd
    // Switches pass the partner register, so let two edges go by
    task automatic sw(input logic [5:0] w);
        @(posedge clk_sys);
        want <= w;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : sw
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic ramp_select;
        for (int i = 0; i < 4; i++) wr(drtsc_pkg::ADDR_ACC0 + 8'(4 * i), 32'h11 + i);
        wr(drtsc_pkg::ADDR_SWFREQ, 32'h3e8);
        output_freq <= 17'h3e7;
        sw(6'h00);
        chk(ramp_set, 2'h0);
        @(posedge clk_sys) output_freq <= 17'h3e8;
        sw(6'h00);
        chk(ramp_set, 2'h3);
        wr(drtsc_pkg::ADDR_CTRL, 32'h18);
        for (int i = 0; i < 4; i++) begin
            sw(6'(i));
            chk({ramp_set, accel_time}, {2'(i), 16'h11 + 16'(i)});
        end
    endtask : ramp_select
    task automatic stops;
        sw(6'h08);
        chk(freq_ref, drtsc_pkg::RST_JOG_FREQ);
        wr(drtsc_pkg::ADDR_ESTOP, 32'h123);
        output_freq <= 17'h1f4;
        sw(6'h04);
        sw(6'h14);
        chk({halt_ind, decel_time}, {1'b1, 16'h0123});
        rd(drtsc_pkg::ADDR_IRQ_STAT);
        chk(got, 32'h1);
        wr(drtsc_pkg::ADDR_IRQ_MASK, 32'hf);
        #1 chk(irq, 1'b1);
        wr(drtsc_pkg::ADDR_IRQ_STAT, 32'h1);
        #1 chk(irq, 1'b0);
        @(posedge clk_sys) output_freq <= 17'h0;
        sw(6'h04);
        chk({run_active, halt_ind}, 2'h1);
        sw(6'h00);
        sw(6'h04);
        chk({run_active, halt_ind, output_enable}, 3'h5);
        chk(freq_ref, main_ref);
        sw(6'h24);
        chk(output_enable, 1'b0);
        rd(drtsc_pkg::ADDR_IRQ_STAT);
        chk(got, 32'h2);
        sw(6'h00);
        wr(drtsc_pkg::ADDR_IRQ_STAT, 32'hf);
    endtask : stops
    task automatic settings;
        wr(drtsc_pkg::ADDR_CTRL, 32'h1);
        #1 chk({ref_one, ref_two}, {12'hfff - ain_one, 12'hfff - ain_two});
        wr(drtsc_pkg::ADDR_APP, 32'h2);
        rd(drtsc_pkg::ADDR_IRQ_STAT);
        chk(got, 32'h8);
        wr(drtsc_pkg::ADDR_APP, 32'h1);
        rd(drtsc_pkg::ADDR_PRESET);
        chk(got & 32'h00ff0000, 32'h004f0000);
        wr(drtsc_pkg::ADDR_APP, 32'h4);
        rd(drtsc_pkg::ADDR_PRESET);
        chk(got & 32'h00f703fc, 32'h00970140);
        wr(drtsc_pkg::ADDR_APP, 32'h5);
        rd(drtsc_pkg::ADDR_PRESET);
        chk(got & 32'h00ef0000, 32'h00ef0000);
        rd(drtsc_pkg::ADDR_ACC0);
        chk(got, 32'(drtsc_pkg::PRESET_ACC_TIME));
        rd(drtsc_pkg::ADDR_DEC0);
        chk(got, 32'(drtsc_pkg::PRESET_ACC_TIME));
        wr(drtsc_pkg::ADDR_APP, 32'h3);
        rd(drtsc_pkg::ADDR_PRESET);
        chk(got & 32'h00cf0000, 32'h00cf0000);
        wr(drtsc_pkg::ADDR_APP, 32'h0);
        rd(drtsc_pkg::ADDR_PRESET);
        chk(got & 32'hfffffffc, 32'h0000f000);
        wr(drtsc_pkg::ADDR_DEC0 + 8'h04, 32'h0);
        rd(drtsc_pkg::ADDR_DEC0 + 8'h04);
        chk(got, 32'(drtsc_pkg::TIME_MIN));
        wr(drtsc_pkg::ADDR_JOGACC, 32'hffff);
        rd(drtsc_pkg::ADDR_JOGACC);
        chk(got, 32'(drtsc_pkg::JOG_TIME_MAX));
        wr(drtsc_pkg::ADDR_CTRL, 32'h4);
        #1 chk({ref_one, ref_two}, {ain_one, ain_two});
        for (int i = 0; i < 251; i++) begin
            @(posedge clk_sys) modified_event <= 1'b1;
            @(posedge clk_sys) modified_event <= 1'b0;
        end
        rd(drtsc_pkg::ADDR_MODCNT);
        chk(got, 32'(drtsc_pkg::MOD_LIST_MAX));
        rd(8'hfc);
        chk(got, 32'h0);
    endtask : settings
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        ramp_select();
        stops();
        settings();
        wrap_up();
    end
    initial begin
        #(5000 * 50);
        n_errors++;
        wrap_up();
    end
endmodule : drtsc_ctrl_tb_top
`default_nettype wire
